// ### rtl/acc_pkg.sv
// Package for the conversion control block: map, fields, timing, types
package acc_pkg;
  // Register indices; each register sits at byte address index * 4
  localparam logic [7:0] ACC_IDX_RES_LO  = 8'h24;
  localparam logic [7:0] ACC_IDX_RES_HI  = 8'h25;
  localparam logic [7:0] ACC_IDX_CTRL    = 8'h26;
  localparam logic [7:0] ACC_IDX_CLKSEL  = 8'h27;
  localparam logic [7:0] ACC_IDX_IRQ_STS = 8'h28;
  localparam logic [7:0] ACC_IDX_IRQ_MSK = 8'h29;
  localparam logic [7:0] ACC_A_RES_LO    = {ACC_IDX_RES_LO[5:0], 2'b00};
  localparam logic [7:0] ACC_A_RES_HI    = {ACC_IDX_RES_HI[5:0], 2'b00};
  localparam logic [7:0] ACC_A_CTRL      = {ACC_IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ACC_A_CLKSEL    = {ACC_IDX_CLKSEL[5:0], 2'b00};
  localparam logic [7:0] ACC_A_IRQ_STS   = {ACC_IDX_IRQ_STS[5:0], 2'b00};
  localparam logic [7:0] ACC_A_IRQ_MSK   = {ACC_IDX_IRQ_MSK[5:0], 2'b00};

  // Control register fields
  localparam int unsigned ACC_CHAN_LSB  = 0;
  localparam int unsigned ACC_PCR_LSB   = 3;
  localparam int unsigned ACC_EOC_BIT   = 6;
  localparam int unsigned ACC_START_BIT = 7;
  // Clock select fields
  localparam int unsigned ACC_DIV_LSB   = 0;
  localparam int unsigned ACC_TEST_BIT  = 7;

  // Conversion clock divide codes and their last counter values
  localparam logic [1:0] ACC_SEL_DIV2  = 2'h0;
  localparam logic [1:0] ACC_SEL_DIV8  = 2'h1;
  localparam logic [1:0] ACC_SEL_DIV32 = 2'h2;
  localparam logic [4:0] ACC_LIM_DIV2  = 5'h01;
  localparam logic [4:0] ACC_LIM_DIV8  = 5'h07;
  localparam logic [4:0] ACC_LIM_DIV32 = 5'h1f;

  // Conversion timing in conversion-clock periods
  localparam int unsigned ACC_RES_W        = 12;
  localparam logic [6:0]  ACC_SAMPLE_LAST  = 7'h1f;  // 32 periods
  localparam logic [6:0]  ACC_CONV_LAST    = 7'h4f;  // 80 periods
  localparam logic [1:0]  ACC_SLOT_LAST    = 2'h3;   // 4 periods a bit
  localparam logic [11:0] ACC_SAR_MSB      = 12'h800;

  // Interrupt status bits
  localparam int unsigned ACC_IRQ_W     = 2;
  localparam int unsigned ACC_IRQ_DONE  = 0;
  localparam int unsigned ACC_IRQ_ABORT = 1;

  localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACC_ST_IDLE   = 2'b00,
    ACC_ST_HOLD   = 2'b01,
    ACC_ST_SAMPLE = 2'b10,
    ACC_ST_CONV   = 2'b11
  } acc_state_t;

  // Signals towards the analog converter
  typedef struct packed {
    logic        power_on;
    logic        conv_reset;
    logic        sample;
    logic [2:0]  chan;
    logic [11:0] trial;
  } acc_afe_t;

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 arready;
    logic                 aw_ok;
    logic [7:0]           aw_addr;
    logic                 w_ok;
    logic [7:0]           w_data;
    logic                 w_lane0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic [2:0]           chan;
    logic [2:0]           pcr;
    logic                 eoc_n;
    logic                 start;
    logic [1:0]           div_sel;
    logic                 test;
    logic [11:0]          res;
    logic [ACC_IRQ_W-1:0] sts;
    logic [ACC_IRQ_W-1:0] msk;
    logic                 irq;
    acc_state_t           st;
    logic [6:0]           ticks;
    logic [11:0]          sar;
    logic [11:0]          bitp;
    logic                 cmp_meta;
    logic                 cmp_sync;
    logic [7:0]           pb_analog;
    acc_afe_t             afe;
  } acc_core_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
    logic       clk;
  } acc_div_t;

  // Lines 0..n-1 of port B become analog; n = 7 makes all eight lines analog
  function automatic logic [7:0] acc_pin_mask(input logic [2:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (3'(i) < n) || (n == 3'h7);
    end
    return m;
  endfunction
endpackage

// ### rtl/acc_clk_div.sv
// Conversion clock divider: one tick per conversion-clock period
`timescale 1ns/1ps
`default_nettype none
module acc_clk_div
  import acc_pkg::*;
#(
  parameter int unsigned CNT_W = 5
) (
  input  wire logic       aclk,     // System clock
  input  wire logic       aresetn,  // Synchronous reset, low
  input  wire logic [1:0] div_sel,  // Divide code
  input  wire logic       restart,  // Realign period to now
  output logic            tick,     // One pulse per period
  output logic            conv_clk  // Divided clock level
);
  if (CNT_W != 5) begin : g_bad_width
    $error("acc_clk_div: CNT_W must be 5");
  end

  acc_div_t   q;
  acc_div_t   n;
  logic [4:0] lim;

  always_comb begin
    n = q;
    case (div_sel)
      ACC_SEL_DIV2:  lim = ACC_LIM_DIV2;
      ACC_SEL_DIV8:  lim = ACC_LIM_DIV8;
      ACC_SEL_DIV32: lim = ACC_LIM_DIV32;
      default:       lim = ACC_LIM_DIV32;  // Undefined code: slowest is safest
    endcase
    n.tick = !restart && (q.cnt == lim);
    n.cnt  = (restart || q.cnt >= lim) ? 5'h00 : q.cnt + 5'h01;
    n.clk  = n.cnt > (lim >> 1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick     = q.tick;
  assign conv_clk = q.clk;

  a_div2_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && div_sel == ACC_SEL_DIV2 && !restart) ##1 (div_sel == ACC_SEL_DIV2 && !restart)
    |=> tick)
    else $error("divide by 2 tick period wrong");
endmodule
`default_nettype wire

// ### rtl/acc_core.sv
// Conversion control block with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Control bits 2..0 pick one of eight analog inputs for the converter.
// - Control bits 5..3 give count n; port B lines 0..n-1 become analog, all eight for n = 7.
// - Pin configuration all zero powers the converter down.
// - Analog lines lose digital function and pull-up; converter powered on.
// - Control bit 6 is the completion flag, cleared when a conversion finishes.
// - Start bit rising sets the completion flag and holds the converter in reset.
// - Start bit rising then falling begins a conversion.
// - Clock select 00, 01, 10 divide system clock by 2, 8, 32.
// - High byte holds result 11..4; low byte bits 7..4 hold result 3..0.
// - Result registers are read-only; writes leave them unchanged.
// - A conversion takes 80 conversion clocks, the first 32 sampling.
module acc_core
  import acc_pkg::*;
#(
  parameter int unsigned RES_W = ACC_RES_W
) (
  input  wire logic        aclk,       // System clock
  input  wire logic        aresetn,    // Synchronous reset, low
  input  wire logic [31:0] awaddr,     // Write address
  input  wire logic        awvalid,    // Write address valid
  output logic             awready,    // Write address ready
  input  wire logic [31:0] wdata,      // Write data
  input  wire logic [3:0]  wstrb,      // Write byte enables
  input  wire logic        wvalid,     // Write data valid
  output logic             wready,     // Write data ready
  output logic [1:0]       bresp,      // Write response
  output logic             bvalid,     // Write response valid
  input  wire logic        bready,     // Write response ready
  input  wire logic [31:0] araddr,     // Read address
  input  wire logic        arvalid,    // Read address valid
  output logic             arready,    // Read address ready
  output logic [31:0]      rdata,      // Read data
  output logic [1:0]       rresp,      // Read response
  output logic             rvalid,     // Read data valid
  input  wire logic        rready,     // Read data ready
  input  wire logic        cmp_in,     // Comparator: input above trial code
  output acc_afe_t         afe,        // Converter control
  output logic             conv_clk,   // Conversion clock
  output logic [7:0]       pb_analog,  // Port B lines in analog use
  output logic             irq         // Level interrupt
);
  if (RES_W != 12) begin : g_bad_res
    $error("acc_core: result registers are packed for 12 bits");
  end

  acc_core_t            q;
  acc_core_t            n;
  logic                 tick;
  logic                 div_restart;
  logic                 do_write;
  logic                 start_rise;
  logic                 start_fall;
  logic [ACC_IRQ_W-1:0] ev;

  acc_clk_div #(
    .CNT_W (5)
  ) u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .div_sel  (q.div_sel),
    .restart  (div_restart),
    .tick     (tick),
    .conv_clk (conv_clk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n           = q;
    do_write    = 1'b0;
    div_restart = 1'b0;
    ev          = '0;

    // Address and data may arrive in either order
    if (q.awready && awvalid) begin
      n.aw_ok   = 1'b1;
      n.aw_addr = awaddr[7:0];
    end
    if (q.wready && wvalid) begin
      n.w_ok    = 1'b1;
      n.w_data  = wdata[7:0];
      n.w_lane0 = wstrb[0];
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_ok && n.w_ok && !n.bvalid) begin
      do_write = 1'b1;
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = ACC_RESP_OKAY;
    end
    if (do_write) begin
      case (n.aw_addr)
        ACC_A_CTRL: begin
          if (n.w_lane0) begin
            n.chan  = n.w_data[ACC_CHAN_LSB +: 3];
            n.pcr   = n.w_data[ACC_PCR_LSB +: 3];
            n.start = n.w_data[ACC_START_BIT];
          end
        end
        ACC_A_CLKSEL: begin
          if (n.w_lane0) begin
            n.div_sel = n.w_data[ACC_DIV_LSB +: 2];
            n.test    = n.w_data[ACC_TEST_BIT];  // Stored only, no effect
          end
        end
        ACC_A_IRQ_STS: begin
          if (n.w_lane0) begin
            n.sts = q.sts & ~n.w_data[ACC_IRQ_W-1:0];
          end
        end
        ACC_A_IRQ_MSK: begin
          if (n.w_lane0) begin
            n.msk = n.w_data[ACC_IRQ_W-1:0];
          end
        end
        ACC_A_RES_LO, ACC_A_RES_HI: begin
          n.bresp = ACC_RESP_OKAY;
        end
        default: n.bresp = ACC_RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready  = !n.w_ok && !n.bvalid;

    // Read channel, one outstanding
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (q.arready && arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = ACC_RESP_OKAY;
      case (araddr[7:0])
        ACC_A_RES_LO:    n.rdata = {q.res[3:0], 4'h0};
        ACC_A_RES_HI:    n.rdata = q.res[11:4];
        ACC_A_CTRL:      n.rdata = {q.start, q.eoc_n, q.pcr, q.chan};
        ACC_A_CLKSEL:    n.rdata = {q.test, 5'h00, q.div_sel};
        ACC_A_IRQ_STS:   n.rdata = {6'h00, q.sts};
        ACC_A_IRQ_MSK:   n.rdata = {6'h00, q.msk};
        default: begin
          n.rdata = 8'h00;
          n.rresp = ACC_RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;

    // Comparator crosses from the analog side
    n.cmp_meta = cmp_in;
    n.cmp_sync = q.cmp_meta;

    n.pb_analog    = acc_pin_mask(q.pcr);
    n.afe.power_on = (q.pcr != 3'h0);

    start_rise = !q.start && n.start;
    start_fall = q.start && !n.start;

    case (q.st)
      ACC_ST_IDLE: begin
        n.st = ACC_ST_IDLE;
      end
      ACC_ST_HOLD: begin
        if (start_fall) begin
          n.st             = ACC_ST_SAMPLE;
          n.ticks          = 7'h00;
          n.afe.chan       = n.chan;
          n.afe.conv_reset = 1'b0;
          n.afe.sample     = 1'b1;
          div_restart      = 1'b1;
        end
      end
      ACC_ST_SAMPLE: begin
        if (tick) begin
          n.ticks = q.ticks + 7'h01;
          if (q.ticks == ACC_SAMPLE_LAST) begin
            n.st         = ACC_ST_CONV;
            n.afe.sample = 1'b0;
            n.sar        = 12'h000;
            n.bitp       = ACC_SAR_MSB;
          end
        end
      end
      ACC_ST_CONV: begin
        if (tick) begin
          n.ticks = q.ticks + 7'h01;
          // Each bit gets four periods for the comparator to settle
          if (q.ticks[1:0] == ACC_SLOT_LAST) begin
            n.sar  = q.sar | (q.cmp_sync ? q.bitp : 12'h000);
            n.bitp = q.bitp >> 1;
          end
          if (q.ticks == ACC_CONV_LAST) begin
            n.res   = n.sar;
            n.eoc_n = 1'b0;
            n.st    = ACC_ST_IDLE;
            ev[ACC_IRQ_DONE] = 1'b1;
          end
        end
      end
      default: n.st = ACC_ST_IDLE;
    endcase
    n.afe.trial = n.sar | n.bitp;

    // A new start always wins, even mid-conversion
    if (start_rise) begin
      n.eoc_n          = 1'b1;
      n.st             = ACC_ST_HOLD;
      n.afe.conv_reset = 1'b1;
      n.afe.sample     = 1'b0;
      n.sar            = 12'h000;
      n.bitp           = 12'h000;
      n.afe.trial      = 12'h000;
      n.res            = q.res;
      ev[ACC_IRQ_ABORT] = (q.st == ACC_ST_SAMPLE) || (q.st == ACC_ST_CONV);
      ev[ACC_IRQ_DONE]  = 1'b0;
    end

    // Hardware set beats a software clear in the same cycle
    n.sts = n.sts | ev;
    n.irq = |(n.sts & n.msk);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign awready   = q.awready;
  assign wready    = q.wready;
  assign bvalid    = q.bvalid;
  assign bresp     = q.bresp;
  assign arready   = q.arready;
  assign rvalid    = q.rvalid;
  assign rresp     = q.rresp;
  assign rdata     = {24'h000000, q.rdata};
  assign afe       = q.afe;
  assign pb_analog = q.pb_analog;
  assign irq       = q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  a_chan_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ACC_ST_SAMPLE || q.st == ACC_ST_CONV) ##1 (q.st != ACC_ST_HOLD)
    |-> $stable(afe.chan))
    else $error("channel changed during a conversion");

  a_chan_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ACC_ST_HOLD && start_fall) |=> afe.chan == $past(n.chan))
    else $error("started channel differs from selection");

  a_pin_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 pb_analog == acc_pin_mask($past(q.pcr)))
    else $error("port B analog mask wrong");

  a_power_state: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 afe.power_on == ($past(q.pcr) != 3'h0))
    else $error("converter power does not follow configuration");

  a_start_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    start_rise |=> q.eoc_n && afe.conv_reset && q.st == ACC_ST_HOLD)
    else $error("start rise did not reset converter");

  a_fall_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ACC_ST_HOLD && start_fall) |=> q.st == ACC_ST_SAMPLE && afe.sample
    && !afe.conv_reset)
    else $error("start fall did not begin sampling");

  a_sample_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ACC_ST_SAMPLE && tick && !start_rise && q.ticks == ACC_SAMPLE_LAST)
    |=> q.st == ACC_ST_CONV && !afe.sample && q.ticks == 7'h20)
    else $error("sampling phase length wrong");

  a_conv_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ACC_ST_CONV && tick && !start_rise && q.ticks == ACC_CONV_LAST)
    |=> !q.eoc_n && q.st == ACC_ST_IDLE && q.sts[ACC_IRQ_DONE])
    else $error("conversion end not flagged");

  a_result_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(q.res) |-> $fell(q.eoc_n))
    else $error("result changed outside conversion end");

  a_eoc_only_end: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(q.eoc_n) |-> $past(q.st) == ACC_ST_CONV && $past(q.ticks) == ACC_CONV_LAST)
    else $error("completion flag cleared early");
endmodule
`default_nettype wire

// ### test/acc_core_tb.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module acc_core_tb
  import acc_pkg::*;
;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr  = 32'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] araddr  = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        cmp_in  = 1'b0;
  logic        awready, wready, arready, bvalid, rvalid, conv_clk, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  pb_analog;
  acc_afe_t    afe;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          samp_cnt   = 0;
  int          cyc        = 0;
  int          rise_cnt   = 0;
  logic        conv_clk_q = 1'b0;

  always #12.5 aclk = ~aclk;
  // Non-blocking for cyc and rise_cnt so tasks waking on the same edge always see the old count
  always @(posedge aclk) begin
    cyc        <= cyc + 1;
    conv_clk_q <= conv_clk;
    if (conv_clk === 1'b1 && conv_clk_q === 1'b0) rise_cnt <= rise_cnt + 1;
    if (afe.sample === 1'b1) samp_cnt++;
  end

  acc_core i_acc_core (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmp_in(cmp_in),
    .afe(afe), .conv_clk(conv_clk), .pb_analog(pb_analog), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_rng(input string nm, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Both channels offered together; each dropped on its own take edge
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic ad, wd;
    int   n;
    ad = 1'b0;
    wd = 1'b0;
    n  = 0;
    @(posedge aclk);
    awaddr  <= {24'h0, a};
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd && bvalid === 1'b1) && n < 50) begin
      @(posedge aclk);
      n++;
      if (ad && wd && bvalid === 1'b1) r = bresp;
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    if (n >= 50) check_val("write_timeout", 32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ad;
    int   n;
    ad = 1'b0;
    n  = 0;
    @(posedge aclk);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!(ad && rvalid === 1'b1) && n < 50) begin
      @(posedge aclk);
      n++;
      if (ad && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
      end
      if (!ad && arready === 1'b1) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    if (n >= 50) check_val("read_timeout", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'h1, r);
    check_val("bresp", {30'h0, ACC_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check_val("rresp", {30'h0, ACC_RESP_OKAY}, {30'h0, r});
    check_val(nm, {24'h0, e}, d);
  endtask

  task automatic settle;
    @(posedge aclk);
    #1;
  endtask

  function automatic logic [7:0] pin_exp(input int n);
    return (n == 7) ? 8'hff : 8'((16'h1 << n) - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk("ctrl_rst", ACC_A_CTRL, 8'h00);
    rd_chk("clksel_rst", ACC_A_CLKSEL, 8'h00);
    check_val("pb_rst", 32'h0, {24'h0, pb_analog});
    check_val("pwr_rst", 32'h0, {31'h0, afe.power_on});
  endtask

  task automatic t_pins;
    for (int n = 7; n >= 0; n--) begin
      wr(ACC_A_CTRL, 8'(n << 3));
      settle;
      check_val("pb_analog", {24'h0, pin_exp(n)}, {24'h0, pb_analog});
      check_val("power_on", {31'h0, n != 0}, {31'h0, afe.power_on});
      if (n != 0) begin
        wr(ACC_A_CTRL, 8'h80 | 8'(n << 3));
        wr(ACC_A_CTRL, 8'(n << 3));
      end
    end
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    wr(ACC_A_CLKSEL, 8'h7f);
    rd_chk("clksel_unused", ACC_A_CLKSEL, 8'h03);
    axi_wr(ACC_A_CLKSEL, 8'h00, 4'h0, r);
    check_val("bresp_nostrb", {30'h0, ACC_RESP_OKAY}, {30'h0, r});
    rd_chk("clksel_nostrb", ACC_A_CLKSEL, 8'h03);
    axi_wr(8'ha8, 8'h01, 4'h1, r);
    check_val("bresp_unmapped", {30'h0, ACC_RESP_SLVERR}, {30'h0, r});
    axi_rd(8'ha8, d, r);
    check_val("rresp_unmapped", {30'h0, ACC_RESP_SLVERR}, {30'h0, r});
    check_val("rdata_unmapped", 32'h0, d);
  endtask

  task automatic t_conv(input logic [1:0] code, input logic c, input logic [2:0] ch,
                        input int div);
    int c0;
    int r0;
    cmp_in <= c;
    wr(ACC_A_CLKSEL, {6'h0, code});
    wr(ACC_A_IRQ_MSK, 8'h01);
    wr(ACC_A_CTRL, 8'hb8 | {5'h0, ch});
    rd_chk("ctrl_hold", ACC_A_CTRL, 8'hf8 | {5'h0, ch});
    check_val("conv_reset", 32'h1, {31'h0, afe.conv_reset});
    wr(ACC_A_IRQ_STS, 8'h03);
    samp_cnt = 0;
    wr(ACC_A_CTRL, 8'h38 | {5'h0, ch});
    c0 = cyc;
    r0 = rise_cnt;
    settle;
    check_val("chan", {29'h0, ch}, {29'h0, afe.chan});
    wr(ACC_A_CTRL, 8'h38 | {5'h0, ~ch});
    settle;
    check_val("chan_held", {29'h0, ch}, {29'h0, afe.chan});
    // Start stays low until completion
    while (irq !== 1'b1 && cyc - c0 < 5000) @(posedge aclk);
    check_rng("conv_cycles", 80 * div - 1, 80 * div + 6, cyc - c0);
    check_rng("conv_clk_periods", 79, 81, rise_cnt - r0);
    check_val("trial_final", c ? 32'hfff : 32'h0, {20'h0, afe.trial});
    check_rng("sample_cycles", 32 * div - 2, 32 * div + 2, samp_cnt);
    rd_chk("ctrl_done", ACC_A_CTRL, 8'h38 | {5'h0, ~ch});
    rd_chk("res_hi", ACC_A_RES_HI, c ? 8'hff : 8'h00);
    rd_chk("res_lo", ACC_A_RES_LO, c ? 8'hf0 : 8'h00);
    wr(ACC_A_RES_HI, 8'h5a);
    wr(ACC_A_RES_LO, 8'ha5);
    rd_chk("res_hi_ro", ACC_A_RES_HI, c ? 8'hff : 8'h00);
    rd_chk("res_lo_ro", ACC_A_RES_LO, c ? 8'hf0 : 8'h00);
  endtask

  task automatic t_irq;
    wr(ACC_A_IRQ_MSK, 8'h00);
    settle;
    check_val("irq_masked", 32'h0, {31'h0, irq});
    rd_chk("sts_done", ACC_A_IRQ_STS, 8'h01);
    wr(ACC_A_IRQ_STS, 8'h01);
    rd_chk("sts_clr", ACC_A_IRQ_STS, 8'h00);
    wr(ACC_A_CTRL, 8'hb8);
    wr(ACC_A_CTRL, 8'h38);
    repeat (20) @(posedge aclk);
    wr(ACC_A_CTRL, 8'hb8);
    rd_chk("sts_abort", ACC_A_IRQ_STS, 8'h02);
    wr(ACC_A_IRQ_MSK, 8'h02);
    settle;
    check_val("irq_set", 32'h1, {31'h0, irq});
    wr(ACC_A_IRQ_STS, 8'h02);
    settle;
    check_val("irq_clr", 32'h0, {31'h0, irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_pins;
    t_regs;
    t_conv(ACC_SEL_DIV2, 1'b1, 3'h5, 2);
    t_conv(ACC_SEL_DIV8, 1'b0, 3'h2, 8);
    t_conv(ACC_SEL_DIV32, 1'b1, 3'h7, 32);
    t_irq;
    final_report;
  end

  // Whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report;
  end
endmodule
`default_nettype wire
